// ---- rtl/rspm_pkg.sv ----
package rspm_pkg;

  localparam int STACK_DEPTH = 16;
  localparam int ADDR_W      = 15;
  localparam int IDX_W       = 5;
  localparam int FULL_PC_W   = 16;

  localparam logic [IDX_W-1:0] IDX_EMPTY = 5'h00;
  localparam logic [IDX_W-1:0] IDX_FULL  = 5'h10;
  localparam logic [3:0]       WRAP_SLOT = 4'h0;

  localparam logic [FULL_PC_W-1:0] PROG_UNIMPL_BASE = 16'h4000;
  localparam logic [FULL_PC_W-1:0] PROG_UNIMPL_LAST = 16'h7FFF;

  // register byte offsets on the avalon bus
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_STATUS   = 5'h04;
  localparam logic [4:0] OFS_MASK     = 5'h08;
  localparam logic [4:0] OFS_INDEX    = 5'h0C;
  localparam logic [4:0] OFS_TOS_LOW  = 5'h10;
  localparam logic [4:0] OFS_TOS_HIGH = 5'h14;
  localparam logic [4:0] OFS_PC       = 5'h18;

  localparam int BIT_ERR_RST_EN = 0;
  localparam int BIT_OVF        = 0;
  localparam int BIT_UNF        = 1;

  localparam logic       CTRL_RESET   = 1'b0;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET   = 2'h0;

  typedef struct packed {
    logic              push;
    logic              pop;
    logic [ADDR_W-1:0] retAddr;
  } rspm_core_req_t;

  typedef struct packed {
    logic              valid;
    logic [FULL_PC_W-1:0] payload;
  } rspm_load_cmd_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } rspm_bus_state_t;

endpackage

// ---- rtl/rspm_stack_mem.sv ----
`timescale 1ns/10ps
// return addresses live here only; the bus reaches this array only through the TOS read registers
module rspm_stack_mem
  import rspm_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              wrEn,
  input  wire logic [3:0]        wrSlot,
  input  wire logic [ADDR_W-1:0] wrData,
  input  wire logic [3:0]        rdSlot,
  output logic      [ADDR_W-1:0] rdData
);

  logic [ADDR_W-1:0] entries [STACK_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      entries[wrSlot] <= wrData;
    end
  end

  assign rdData = entries[rdSlot];

endmodule

// ---- rtl/rspm_addr_map.sv ----
`timescale 1ns/10ps
module rspm_addr_map
  import rspm_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [FULL_PC_W-1:0] programCounter,
  input  rspm_load_cmd_t            loadCmd,
  input  wire logic [13:0]          progMemRdata,
  input  wire logic                 dataLocImpl,
  input  wire logic [7:0]           dataMemRdata,
  output logic      [ADDR_W-1:0]    fetchAddr_r,
  output logic      [FULL_PC_W-1:0] nvmAddr_r,
  output logic      [13:0]          progRdata_r,
  output logic      [7:0]           dataRdata_r
);

  wire logic progUnimpl;
  assign progUnimpl = (nvmAddr_r >= PROG_UNIMPL_BASE) && (nvmAddr_r <= PROG_UNIMPL_LAST);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fetchAddr_r <= 15'h0000;
      nvmAddr_r   <= 16'h0000;
      progRdata_r <= 14'h0000;
      dataRdata_r <= 8'h00;
    end else begin
      fetchAddr_r <= programCounter[ADDR_W-1:0];
      if (loadCmd.valid) begin
        nvmAddr_r <= loadCmd.payload;
      end
      progRdata_r <= progUnimpl ? 14'h0000 : progMemRdata;
      dataRdata_r <= dataLocImpl ? dataMemRdata : 8'h00;
    end
  end

endmodule

// ---- rtl/rspm_return_stack.sv ----
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
//Contract
//- return addresses held in private separate array
//- reset disabled: push onto full stack leaves index at 0x10
//- reset disabled: full push overwrites entry 0x00
//- reset enabled: full push resets, entry kept
//- enabled: overflow/underflow resets and sets flag
//- programming load takes full 16-bit address
//- unimplemented program region 4000h reads zero
//- unimplemented data locations read zero
module rspm_return_stack
  import rspm_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // avalon-mm slave
  input  wire logic [4:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // core call / return / interrupt sequencing
  input  rspm_core_req_t            coreReq,
  output logic      [ADDR_W-1:0]    popAddr_r,
  output logic                      popValid_r,
  output logic                      stackResetReq_r,
  // program counter and memory map
  input  wire logic [FULL_PC_W-1:0] programCounter,
  input  rspm_load_cmd_t            loadCmd,
  input  wire logic [13:0]          progMemRdata,
  input  wire logic                 dataLocImpl,
  input  wire logic [7:0]           dataMemRdata,
  output logic      [ADDR_W-1:0]    fetchAddr,
  output logic      [FULL_PC_W-1:0] nvmAddr,
  output logic      [13:0]          progRdata,
  output logic      [7:0]           dataRdata,
  output logic                      irq
);

  // software-visible state
  logic                   errRstEn_r;
  logic [1:0]             status_r;
  logic [1:0]             status_nxt;
  logic [1:0]             mask_r;
  logic [IDX_W-1:0]       index_r;
  logic [IDX_W-1:0]       index_nxt;

  // bus handshake
  rspm_bus_state_t        busState_r;
  logic [31:0]            rdMux;

  // stack datapath
  logic                   memWrEn;
  logic [3:0]             memWrSlot;
  logic [3:0]             memRdSlot;
  logic [ADDR_W-1:0]      memRdData;
  logic [ADDR_W-1:0]      tosAddr;

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, then answer at the second edge
  // ---------------------------------------------------------------
  wire logic busReq;
  wire logic busAccept;
  wire logic wrAccept;
  wire logic lane0;
  wire logic selCtrl;
  wire logic selStatus;
  wire logic selMask;
  wire logic selIndex;

  assign busReq      = read | write;
  assign busAccept   = busReq & (busState_r == BUS_ACK);
  assign waitrequest = busReq & (busState_r != BUS_ACK);
  assign wrAccept    = write & busAccept;
  assign lane0       = byteenable[0];
  assign selCtrl     = wrAccept & lane0 & (address == OFS_CTRL);
  assign selStatus   = wrAccept & lane0 & (address == OFS_STATUS);
  assign selMask     = wrAccept & lane0 & (address == OFS_MASK);
  assign selIndex    = wrAccept & lane0 & (address == OFS_INDEX);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busState_r <= BUS_IDLE;
    end else begin
      case (busState_r)
        BUS_IDLE: begin
          if (busReq) begin
            busState_r <= BUS_ACK;
          end
        end
        BUS_ACK: busState_r <= BUS_IDLE;
        default: busState_r <= BUS_IDLE;
      endcase
    end
  end

  // unmapped offsets read zero and ignore writes
  always_comb begin
    rdMux = 32'h0000_0000;
    case (address)
      OFS_CTRL:     rdMux[BIT_ERR_RST_EN] = errRstEn_r;
      OFS_STATUS:   rdMux[1:0] = status_r;
      OFS_MASK:     rdMux[1:0] = mask_r;
      OFS_INDEX:    rdMux[IDX_W-1:0] = index_r;
      OFS_TOS_LOW:  rdMux[7:0] = tosAddr[7:0];
      OFS_TOS_HIGH: rdMux[6:0] = tosAddr[ADDR_W-1:8];
      OFS_PC:       rdMux[FULL_PC_W-1:0] = programCounter;
      default:      rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && busState_r == BUS_IDLE) begin
      readdata <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // stack control
  // index counts live entries: 0x00 empty, 0x10 full
  // ---------------------------------------------------------------
  wire logic isFull;
  wire logic isEmpty;
  wire logic doPush;
  wire logic doPop;
  wire logic ovfEvent;
  wire logic unfEvent;
  wire logic errReset;

  assign isFull   = (index_r == IDX_FULL);
  assign isEmpty  = (index_r == IDX_EMPTY);
  // push wins if core asks both at once; a real core never does
  assign doPush   = coreReq.push;
  assign doPop    = coreReq.pop & ~coreReq.push;
  assign ovfEvent = doPush & isFull;
  assign unfEvent = doPop & isEmpty;
  assign errReset = errRstEn_r & (ovfEvent | unfEvent);

  // entry 0x00 is only overwritten by a wrap when reset is disabled
  assign memWrEn   = doPush & ~(isFull & errRstEn_r);
  assign memWrSlot = isFull ? WRAP_SLOT : index_r[3:0];
  assign memRdSlot = isEmpty ? 4'h0 : 4'(index_r - 5'h01);
  assign tosAddr   = isEmpty ? 15'h0000 : memRdData;

  rspm_stack_mem u_stack_mem (
    .core_clk (core_clk),
    .wrEn     (memWrEn),
    .wrSlot   (memWrSlot),
    .wrData   (coreReq.retAddr),
    .rdSlot   (memRdSlot),
    .rdData   (memRdData)
  );

  always_comb begin
    index_nxt = index_r;
    if (errReset) begin
      // the device reset empties the stack
      index_nxt = IDX_EMPTY;
    end else if (doPush) begin
      index_nxt = isFull ? IDX_FULL : 5'(index_r + 5'h01);
    end else if (doPop) begin
      index_nxt = isEmpty ? IDX_EMPTY : 5'(index_r - 5'h01);
    end else if (selIndex) begin
      // software may move the index; values past full saturate
      index_nxt = (writedata[IDX_W-1:0] > IDX_FULL) ? IDX_FULL : writedata[IDX_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      index_r <= IDX_EMPTY;
    end else begin
      index_r <= index_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      popAddr_r       <= 15'h0000;
      popValid_r      <= 1'b0;
      stackResetReq_r <= 1'b0;
    end else begin
      popValid_r      <= doPop & ~isEmpty;
      stackResetReq_r <= errReset;
      if (doPop && !isEmpty) begin
        popAddr_r <= memRdData;
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags: hardware set wins over a write-one clear
  // flags only raise with reset enabled, as they mark a stack reset
  // ---------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    if (selStatus) begin
      status_nxt = status_r & ~writedata[1:0];
    end
    if (errReset && ovfEvent) begin
      status_nxt[BIT_OVF] = 1'b1;
    end
    if (errReset && unfEvent) begin
      status_nxt[BIT_UNF] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      errRstEn_r <= CTRL_RESET;
      status_r   <= STATUS_RESET;
      mask_r     <= MASK_RESET;
    end else begin
      status_r <= status_nxt;
      if (selCtrl) begin
        errRstEn_r <= writedata[BIT_ERR_RST_EN];
      end
      if (selMask) begin
        mask_r <= writedata[1:0];
      end
    end
  end

  assign irq = |(status_r & mask_r);

  // ---------------------------------------------------------------
  // program counter split and unimplemented-region zeroing
  // ---------------------------------------------------------------
  rspm_addr_map u_addr_map (
    .core_clk       (core_clk),
    .rst            (rst),
    .programCounter (programCounter),
    .loadCmd        (loadCmd),
    .progMemRdata   (progMemRdata),
    .dataLocImpl    (dataLocImpl),
    .dataMemRdata   (dataMemRdata),
    .fetchAddr_r    (fetchAddr),
    .nvmAddr_r      (nvmAddr),
    .progRdata_r    (progRdata),
    .dataRdata_r    (dataRdata)
  );

endmodule

// ---- tb/rspm_chk.sv ----
`timescale 1ns/10ps
module rspm_chk
  import rspm_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst,
  input rspm_core_req_t            coreReq,
  input wire logic [ADDR_W-1:0]    popAddr_r,
  input wire logic                 popValid_r,
  input wire logic                 stackResetReq_r,
  input wire logic [FULL_PC_W-1:0] programCounter,
  input rspm_load_cmd_t            loadCmd,
  input wire logic                 dataLocImpl,
  input wire logic [ADDR_W-1:0]    fetchAddr,
  input wire logic [FULL_PC_W-1:0] nvmAddr,
  input wire logic [13:0]          progRdata,
  input wire logic [7:0]           dataRdata
);
  logic [4:0] depth_r;
  logic       popOnly;
  assign popOnly = coreReq.pop & ~coreReq.push;
  // shadow fill level; blind to software index writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst || stackResetReq_r) begin
      depth_r <= 5'h00;
    end else if (coreReq.push && depth_r < IDX_FULL) begin
      depth_r <= depth_r + 5'h01;
    end else if (popOnly && depth_r != IDX_EMPTY) begin
      depth_r <= depth_r - 5'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_fetch_low: assert property (1'b1 |=>
    {1'b0, fetchAddr} == ($past(programCounter) & 16'h7FFF)) else $error("fetch address");
  chk_nvm_full: assert property (loadCmd.valid |=>
    nvmAddr == $past(loadCmd.payload)) else $error("load address");
  chk_prog_gap: assert property (nvmAddr >= PROG_UNIMPL_BASE &&
    nvmAddr <= PROG_UNIMPL_LAST |=> progRdata == 14'h0000) else $error("program gap");
  chk_data_gap: assert property (!dataLocImpl |=>
    dataRdata == 8'h00) else $error("data gap");
  chk_pop_match: assert property (coreReq.push && depth_r < 5'h0F ##1 popOnly
    |=> popValid_r && popAddr_r == $past(coreReq.retAddr, 2)) else $error("pop address");
  chk_pop_cause: assert property (popValid_r |-> $past(popOnly))
    else $error("stray pop");
  chk_rst_cause: assert property (stackResetReq_r |->
    $past(coreReq.push) || $past(coreReq.pop)) else $error("stray reset");
  chk_rst_nopop: assert property (stackResetReq_r |-> !popValid_r)
    else $error("reset with pop");
  cover property (coreReq.push ##1 popOnly);
  cover property (stackResetReq_r);
  cover property (loadCmd.valid && loadCmd.payload[14]);
endmodule

bind rspm_return_stack rspm_chk rspm_chk_inst (.core_clk, .rst, .coreReq, .popAddr_r,
  .popValid_r, .stackResetReq_r, .programCounter, .loadCmd, .dataLocImpl, .fetchAddr,
  .nvmAddr, .progRdata, .dataRdata);

// ---- tb/rspm_core_model.sv ----
`timescale 1ns/10ps
module rspm_core_model
  import rspm_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [ADDR_W-1:0] popAddr_r,
  input  wire logic              popValid_r,
  output rspm_core_req_t         coreReq,
  output rspm_load_cmd_t         loadCmd
);
  initial begin
    coreReq = '0;
    loadCmd = '0;
  end
  // pulses chain back to back until idle closes them
  task automatic pulse(input logic ps, input logic pp, input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    coreReq <= '{push: ps, pop: pp, retAddr: a};
  endtask
  task automatic idle(output logic v, output logic [ADDR_W-1:0] q);
    @(posedge core_clk);
    coreReq <= '0;
    @(negedge core_clk);
    v = popValid_r;
    q = popAddr_r;
  endtask
  task automatic load(input logic [FULL_PC_W-1:0] p);
    @(posedge core_clk);
    loadCmd <= '{valid: 1'b1, payload: p};
    @(posedge core_clk);
    loadCmd.valid <= 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import rspm_pkg::*;
;
  logic [31:0] readdata, writedata, q32;
  logic [15:0] programCounter, nvmAddr;
  logic [14:0] popAddr_r, fetchAddr, q;
  logic [13:0] progMemRdata, progRdata;
  logic [7:0]  dataMemRdata, dataRdata;
  logic [4:0]  address;
  logic        core_clk, rst, read, write, waitrequest, popValid_r, v;
  logic        stackResetReq_r, dataLocImpl, irq;
  rspm_core_req_t coreReq;
  rspm_load_cmd_t loadCmd;
  int          nMismatch, checksDone, nRst, i;
  rspm_return_stack rspm_return_stack_inst (.core_clk, .rst, .address, .read, .write,
    .writedata, .byteenable(4'hF), .readdata, .waitrequest, .coreReq, .popAddr_r,
    .popValid_r, .stackResetReq_r, .programCounter, .loadCmd, .progMemRdata,
    .dataLocImpl, .dataMemRdata, .fetchAddr, .nvmAddr, .progRdata, .dataRdata, .irq);
  rspm_core_model rspm_core_model_inst (.core_clk, .popAddr_r, .popValid_r, .coreReq,
    .loadCmd);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (stackResetReq_r === 1'b1) nRst <= nRst + 1;
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // waitrequest and readdata taken at the rising edge, before its updates land
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q32 = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) nMismatch++;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), q32, e);
  endtask
  task automatic push(input logic [14:0] a);
    rspm_core_model_inst.pulse(1'b1, 1'b0, a);
    rspm_core_model_inst.idle(v, q);
  endtask
  task automatic pop();
    rspm_core_model_inst.pulse(1'b0, 1'b1, 15'h0);
    rspm_core_model_inst.idle(v, q);
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400000;
    nMismatch++;
    stopTest;
  end
  initial begin
    {rst, read, write, address, writedata, dataLocImpl} = {3'b100, 5'h00, 32'h0, 1'b1};
    {programCounter, progMemRdata, dataMemRdata} = {16'h0, 14'h2AAA, 8'h5A};
    {nMismatch, checksDone, nRst} = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rd(5'(4 * i), 32'h0);
    bus(1'b1, 5'h1C, 32'hFF);
    rd(5'h1C, 32'h0);
    $display("test reset done");
    rspm_core_model_inst.pulse(1'b1, 1'b0, 15'h7ABC);
    pop();
    check("bounce", {v, q}, {1'b1, 15'h7ABC});
    push(15'h5A3C);
    rd(OFS_INDEX, 32'h1);
    rd(OFS_TOS_LOW, 32'h3C);
    rd(OFS_TOS_HIGH, 32'h5A);
    pop();
    check("pop", {v, q}, {1'b1, 15'h5A3C});
    $display("test call done");
    for (i = 0; i < 17; i++) push(15'h1000 + 15'(i));
    rd(OFS_INDEX, 32'h10);
    for (i = 15; i >= 0; i--) begin
      pop();
      check("wrap", q, (i == 0) ? 15'h1010 : 15'h1000 + 15'(i));
    end
    pop();
    check("empty", v, 1'b0);
    rd(OFS_STATUS, 32'h0);
    $display("test wrap done");
    bus(1'b1, OFS_CTRL, 32'h1);
    for (i = 0; i < 17; i++) push((i == 16) ? 15'h7FFF : 15'h2A00 + 15'(i));
    rd(OFS_STATUS, 32'h1);
    rd(OFS_INDEX, 32'h0);
    check("resets", nRst, 1);
    bus(1'b1, OFS_INDEX, 32'h1);
    rd(OFS_TOS_LOW, 32'h00);
    pop();
    check("kept", {v, q}, {1'b1, 15'h2A00});
    pop();
    @(negedge core_clk);
    check("underflow", {v, nRst}, {1'b0, 32'h2});
    rd(OFS_STATUS, 32'h3);
    check("irq off", irq, 1'b0);
    bus(1'b1, OFS_MASK, 32'h2);
    @(negedge core_clk);
    check("irq on", irq, 1'b1);
    bus(1'b1, OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h1);
    check("irq clr", irq, 1'b0);
    $display("test error reset done");
    @(posedge core_clk);
    programCounter <= 16'hC123;
    dataLocImpl <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    check("fetch", fetchAddr, 15'h4123);
    check("data", dataRdata, 8'h00);
    rd(OFS_PC, 32'hC123);
    dataLocImpl <= 1'b1;
    rspm_core_model_inst.load(16'h8005);
    @(negedge core_clk);
    check("nvm", nvmAddr, 16'h8005);
    rspm_core_model_inst.load(16'h4000);
    @(posedge core_clk);
    @(negedge core_clk);
    check("gap", {progRdata, dataRdata}, {14'h0, 8'h5A});
    rspm_core_model_inst.load(16'h3FFF);
    @(posedge core_clk);
    @(negedge core_clk);
    check("prog", progRdata, 14'h2AAA);
    $display("test map done");
    stopTest;
  end
endmodule
